// ---- tab_register_bank.sv ----
// Register bank of the temperature sensor and multi-channel converter
`timescale 1ns/100ps

module tab_register_bank #(
	parameter int AUTO_PERIOD = tab_pkg::AUTO_PERIOD_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Byte port from the serial bus engine
	input  wire logic       txn_start,
	input  wire logic       txn_write,
	input  wire logic       txn_end,
	input  wire logic       wr_valid,
	input  wire logic [7:0] wr_byte,
	input  wire logic       rd_req,
	output logic [7:0]      rd_byte,
	output logic            rd_valid,
	// Converter core
	output logic            conv_start,
	output logic [2:0]      conv_channel,
	output logic            ref_amp_enable,
	input  wire logic       conv_done,
	input  wire logic [9:0] conv_code,
	// External conversion start pin, active low
	input  wire logic       conversion_start_pin_n,
	// Configuration levels for neighbouring logic
	output logic [2:0]      fault_queue_depth,
	output logic            alarm_active_high,
	output logic            alarm_interrupt_mode,
	output logic            shutdown,
	output logic            filter_bypass,
	output logic [8:0]      lower_threshold,
	output logic [8:0]      upper_threshold
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Byte position within a transaction
	typedef enum logic [1:0] {
		PORT_POINTER,
		PORT_HIGH,
		PORT_LOW
	} tab_port_type;

	// Converter idle, or a conversion running with the amplifier powered
	typedef enum logic {
		CONV_IDLE,
		CONV_RUN
	} tab_conv_type;

	typedef struct packed {
		logic [7:0]   pointer;
		logic [7:0]   primary;
		logic [8:0]   hysteresis;
		logic [8:0]   overlimit;
		logic [9:0]   temperature;
		logic [9:0]   converter;
		logic [1:0]   secondary;
		tab_port_type port;
		logic [7:0]   rd_byte;
		logic         rd_valid;
		tab_conv_type conv;
		logic         conv_start;
		logic [2:0]   channel;
	} tab_state_type;

	tab_state_type state;
	tab_state_type next_state;

	logic auto_tick;
	logic pin_fall;
	logic auto_mode;
	logic take_write;
	logic take_read;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [2:0] fault_count(input logic [1:0] code);
		unique case (code)
			tab_pkg::FAULT_ONE:  fault_count = 3'h1;
			tab_pkg::FAULT_TWO:  fault_count = 3'h2;
			tab_pkg::FAULT_FOUR: fault_count = 3'h4;
			tab_pkg::FAULT_SIX:  fault_count = 3'h6;
		endcase
	endfunction

	// Returns the 16-bit word of a register; byte-wide ones sit in the low byte
	function automatic logic [15:0] reg_word(input tab_state_type s, input logic [2:0] sel);
		reg_word = 16'h0000;
		case (sel)
			tab_pkg::SEL_TEMPERATURE: reg_word = {s.temperature, 6'h00};
			tab_pkg::SEL_PRIMARY:     reg_word = {8'h00, s.primary};
			tab_pkg::SEL_HYSTERESIS:  reg_word = {s.hysteresis, 7'h00};
			tab_pkg::SEL_OVERLIMIT:   reg_word = {s.overlimit, 7'h00};
			tab_pkg::SEL_CONVERTER:   reg_word = {s.converter, 6'h00};
			tab_pkg::SEL_SECONDARY:   reg_word = {8'h00, s.secondary, 6'h00};
			default:                  reg_word = 16'h0000;
		endcase
	endfunction

	function automatic logic is_byte_reg(input logic [2:0] sel);
		is_byte_reg = (sel == tab_pkg::SEL_PRIMARY) || (sel == tab_pkg::SEL_SECONDARY);
	endfunction

	// Wide registers alternate high and low byte; the pointer phase stays put
	function automatic tab_port_type next_half(input tab_port_type p);
		unique case (p)
			PORT_HIGH: next_half = PORT_LOW;
			PORT_LOW:  next_half = PORT_HIGH;
			default:   next_half = p;
		endcase
	endfunction

	// Byte-wide registers repeat their only byte; wide ones go high byte first
	function automatic logic [7:0] read_byte(input logic [15:0] word, input logic [2:0] sel,
			input tab_port_type p);
		if (is_byte_reg(sel) || (p == PORT_LOW)) begin
			read_byte = word[7:0];
		end else begin
			read_byte = word[15:8];
		end
	endfunction

	// A lone first byte leaves bit 0 alone, so eight-bit users need one byte only
	function automatic logic [8:0] setpoint_merge(input logic [8:0] old, input logic [7:0] data,
			input tab_port_type p);
		setpoint_merge = old;
		if (p == PORT_LOW) begin
			setpoint_merge[0] = data[7];
		end else begin
			setpoint_merge[8:1] = data;
		end
	endfunction

	// ----------------------------------------
	// Byte port decode
	// ----------------------------------------
	// One event per cycle: a start outranks data, data outranks a read
	assign take_write = wr_valid & ~txn_start;
	assign take_read  = rd_req & ~txn_start & ~wr_valid;

	// ----------------------------------------
	// Conversion triggers
	// ----------------------------------------
	assign auto_mode = ~state.secondary[1];

	// Auto conversions restart from each finished bus operation
	tab_tick_timer #(
		.PERIOD (AUTO_PERIOD)
	) u_timer (
		.clk     (clk),
		.nrst    (nrst),
		.enable  (auto_mode & ~state.primary[tab_pkg::SHUTDOWN_BIT]),
		.restart (txn_end),
		.tick    (auto_tick)
	);

	tab_pin_sync u_start_pin (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (conversion_start_pin_n),
		.level (),
		.fall  (pin_fall)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [2:0]  sel;
		logic [15:0] word;
		logic        trigger;
		sel                 = state.pointer[2:0];
		word                = reg_word(state, sel);
		trigger             = 1'b0;
		next_state          = state;
		next_state.rd_valid = 1'b0;
		next_state.conv_start = 1'b0;

		if (txn_start) begin
			// Writes open with the pointer byte; reads go straight to data
			if (txn_write) begin
				next_state.port = PORT_POINTER;
			end else begin
				next_state.port = PORT_HIGH;
			end
		end

		if (take_write) begin
			if (state.port == PORT_POINTER) begin
				next_state.pointer = wr_byte;
				next_state.port    = PORT_HIGH;
			end else begin
				next_state.port = next_half(state.port);
				unique case (sel)
					tab_pkg::SEL_PRIMARY: begin
						next_state.primary = wr_byte;
					end
					tab_pkg::SEL_SECONDARY: begin
						next_state.secondary = wr_byte[7:6];
					end
					tab_pkg::SEL_HYSTERESIS: begin
						next_state.hysteresis = setpoint_merge(state.hysteresis, wr_byte, state.port);
					end
					tab_pkg::SEL_OVERLIMIT: begin
						next_state.overlimit = setpoint_merge(state.overlimit, wr_byte, state.port);
					end
					default: begin
						// Result registers and unmapped selects drop the byte
						next_state.pointer = state.pointer;
					end
				endcase
			end
		end

		if (take_read) begin
			next_state.rd_byte  = read_byte(word, sel, state.port);
			next_state.rd_valid = 1'b1;
			next_state.port     = next_half(state.port);
		end

		// Pin mode ignores the timer; auto mode ignores the pin
		if (auto_mode) begin
			trigger = auto_tick;
		end else begin
			trigger = pin_fall;
		end

		unique case (state.conv)
			CONV_IDLE: begin
				if (trigger) begin
					next_state.conv       = CONV_RUN;
					next_state.conv_start = 1'b1;
					next_state.channel    = state.primary[7:tab_pkg::CHANNEL_LSB];
				end
			end
			CONV_RUN: begin
				// A trigger that lands mid-conversion is lost, not queued
				if (conv_done) begin
					next_state.conv = CONV_IDLE;
					if (state.channel == tab_pkg::CHANNEL_SENSOR) begin
						next_state.temperature = conv_code;
					end else begin
						next_state.converter = conv_code;
					end
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state                <= '0;
			state.pointer        <= tab_pkg::POINTER_RESET;
			state.primary        <= tab_pkg::PRIMARY_RESET;
			state.hysteresis     <= tab_pkg::HYSTERESIS_RESET;
			state.overlimit      <= tab_pkg::OVERLIMIT_RESET;
			state.secondary      <= tab_pkg::SECONDARY_RESET[7:6];
			state.channel        <= tab_pkg::CHANNEL_SENSOR;
			state.port           <= PORT_HIGH;
			state.conv           <= CONV_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rd_byte              = state.rd_byte;
	assign rd_valid             = state.rd_valid;
	assign conv_start           = state.conv_start;
	assign conv_channel         = state.channel;
	assign ref_amp_enable       = (state.conv == CONV_RUN);
	assign fault_queue_depth    = fault_count(state.primary[4:tab_pkg::FAULT_LSB]);
	assign alarm_active_high    = state.primary[tab_pkg::POLARITY_BIT];
	assign alarm_interrupt_mode = state.primary[tab_pkg::MODE_BIT];
	assign shutdown             = state.primary[tab_pkg::SHUTDOWN_BIT];
	assign filter_bypass        = state.secondary[0];
	assign lower_threshold      = state.hysteresis;
	assign upper_threshold      = state.overlimit;

endmodule

// ---- tab_pkg.sv ----
// Package of register map, field layout, reset values and timing for the temperature/converter register bank
package tab_pkg;

	// ----------------------------------------
	// Register selects (low pointer bits)
	// ----------------------------------------
	localparam logic [2:0] SEL_TEMPERATURE = 3'h0;
	localparam logic [2:0] SEL_PRIMARY     = 3'h1;
	localparam logic [2:0] SEL_HYSTERESIS  = 3'h2;
	localparam logic [2:0] SEL_OVERLIMIT   = 3'h3;
	localparam logic [2:0] SEL_CONVERTER   = 3'h4;
	localparam logic [2:0] SEL_SECONDARY   = 3'h5;
	localparam int         SEL_WIDTH       = 3;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int RESULT_LSB     = 6;
	localparam int RESULT_WIDTH   = 10;
	localparam int SETPOINT_LSB   = 7;
	localparam int SETPOINT_WIDTH = 9;
	localparam int CHANNEL_LSB    = 5;
	localparam int FAULT_LSB      = 3;
	localparam int POLARITY_BIT   = 2;
	localparam int MODE_BIT       = 1;
	localparam int SHUTDOWN_BIT   = 0;
	localparam int CONV_MODE_BIT  = 7;
	localparam int FILTER_OFF_BIT = 6;

	// ----------------------------------------
	// Encodings and reset values
	// ----------------------------------------
	localparam logic [2:0] CHANNEL_SENSOR     = 3'h0;
	localparam logic [2:0] CHANNEL_EXT_FOUR   = 3'h4;
	localparam logic [1:0] FAULT_ONE          = 2'h0;
	localparam logic [1:0] FAULT_TWO          = 2'h1;
	localparam logic [1:0] FAULT_FOUR         = 2'h2;
	localparam logic [1:0] FAULT_SIX          = 2'h3;
	localparam logic [7:0] POINTER_RESET      = 8'h00;
	localparam logic [7:0] PRIMARY_RESET      = 8'h00;
	localparam logic [7:0] SECONDARY_RESET    = 8'h00;
	localparam logic [8:0] HYSTERESIS_RESET   = 9'h000;
	localparam logic [8:0] OVERLIMIT_RESET    = 9'h000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS      = 50;
	localparam int AUTO_PERIOD_US     = 355;
	localparam int AUTO_PERIOD_CYCLES = (AUTO_PERIOD_US * 1000) / CLK_PERIOD_NS;

endpackage

// ---- tab_pin_sync.sv ----
// Three-stage pin synchroniser with falling-edge pulse
`timescale 1ns/100ps

module tab_pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Pin side
	input  wire logic pin,
	// Synchronised side
	output logic      level,
	output logic      fall
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic stable;
		logic fall;
	} tab_sync_type;

	tab_sync_type state;
	tab_sync_type next_state;

	always_comb begin
		next_state      = state;
		next_state.ff1  = pin;
		next_state.ff2  = state.ff1;
		next_state.ff3  = state.ff2;
		next_state.fall = 1'b0;
		// A change counts only once two stages agree
		if (state.ff2 == state.ff3) begin
			next_state.stable = state.ff3;
			next_state.fall   = state.stable & ~state.ff3;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= '{ff1: 1'b1, ff2: 1'b1, ff3: 1'b1, stable: 1'b1, fall: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign level = state.stable;
	assign fall  = state.fall;

endmodule

// ---- tab_tick_timer.sv ----
// Restartable periodic tick generator
`timescale 1ns/100ps

module tab_tick_timer #(
	parameter int PERIOD = 7100
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Control
	input  wire logic enable,
	input  wire logic restart,
	// Output
	output logic      tick
);

	localparam int CW = $clog2(PERIOD + 1);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          tick;
	} tab_timer_type;

	tab_timer_type state;
	tab_timer_type next_state;

	always_comb begin
		next_state      = state;
		next_state.tick = 1'b0;
		if (!enable || restart) begin
			next_state.count = '0;
		end else if (state.count == LAST) begin
			next_state.count = '0;
			next_state.tick  = 1'b1;
		end else begin
			next_state.count = state.count + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;

endmodule

// ---- tab_register_bank_asserts.sv ----
// Port-level checks for the temperature/converter register bank
`timescale 1ns/100ps

module tab_register_bank_asserts (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Byte port
	input  wire logic       txn_start,
	input  wire logic       wr_valid,
	input  wire logic       rd_req,
	input  wire logic [7:0] rd_byte,
	input  wire logic       rd_valid,
	// Converter and levels
	input  wire logic       conv_start,
	input  wire logic [2:0] conv_channel,
	input  wire logic       ref_amp_enable,
	input  wire logic       conv_done,
	input  wire logic [2:0] fault_queue_depth,
	input  wire logic [8:0] upper_threshold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Lower-priority read only counts when nothing else is taken
	sequence read_taken;
		rd_req && !txn_start && !wr_valid;
	endsequence
	sequence conv_finish;
		ref_amp_enable && conv_done;
	endsequence

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	read_answer_a: assert property (read_taken |=> rd_valid)
		else $error("read request not answered");
	answer_cause_a: assert property (rd_valid |-> $past(rd_req))
		else $error("read answer without request");
	byte_hold_a: assert property ($changed(rd_byte) |-> rd_valid)
		else $error("read byte moved without answer");
	amp_on_start_a: assert property (conv_start |-> ref_amp_enable)
		else $error("amplifier off at conversion start");
	amp_rise_cause_a: assert property ($rose(ref_amp_enable) |-> conv_start)
		else $error("amplifier on without start");
	amp_off_done_a: assert property (conv_finish |=> !ref_amp_enable)
		else $error("amplifier left on after finish");
	start_single_a: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	channel_hold_a: assert property ($changed(conv_channel) |-> conv_start)
		else $error("channel moved outside start");
	upper_write_a: assert property ($changed(upper_threshold) |-> $past(wr_valid))
		else $error("setpoint moved without data byte");
	fault_code_a: assert property (fault_queue_depth inside {3'h1, 3'h2, 3'h4, 3'h6})
		else $error("fault depth outside legal set");
endmodule

bind tab_register_bank tab_register_bank_asserts chk_u (
	.clk(clk), .nrst(nrst), .txn_start(txn_start), .wr_valid(wr_valid),
	.rd_req(rd_req), .rd_byte(rd_byte), .rd_valid(rd_valid), .conv_start(conv_start),
	.conv_channel(conv_channel), .ref_amp_enable(ref_amp_enable), .conv_done(conv_done),
	.fault_queue_depth(fault_queue_depth), .upper_threshold(upper_threshold)
);

// ---- tab_conv_model.sv ----
// Behavioural converter core answering start pulses after a set delay
`timescale 1ns/100ps

module tab_conv_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Converter handshake
	input  wire logic       conv_start,
	input  wire logic [7:0] delay,
	output logic            conv_done
);
	int unsigned cnt;

	// Delay is taken at start so slow and prompt answers can be mixed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			conv_done <= 1'b0;
		end else begin
			if (conv_start)
				cnt <= delay;
			else if (cnt != 0)
				cnt <= cnt - 1;
			conv_done <= (cnt == 1) && !conv_start;
		end
	end
endmodule

// ---- tb_tab_register_bank.sv ----
// Self-checking testbench of the register bank
`timescale 1ns/100ps

module tb_tab_register_bank;
	localparam int AUTO = 20;
	logic       clk = 0, nrst = 0, txn_start = 0, txn_write = 0, txn_end = 0;
	logic       wr_valid = 0, rd_req = 0, conversion_start_pin_n = 1;
	logic [7:0] wr_byte = 8'h00, dly = 8'h04, rd_byte;
	logic [9:0] conv_code = 10'h000;
	logic       rd_valid, conv_start, ref_amp_enable, conv_done;
	logic       alarm_active_high, alarm_interrupt_mode, shutdown, filter_bypass;
	logic [2:0] conv_channel, fault_queue_depth;
	logic [8:0] lower_threshold, upper_threshold;
	int         n_tests = 0, n_fail = 0;

	tab_register_bank #(.AUTO_PERIOD(AUTO)) dut_u (
		.clk(clk), .nrst(nrst), .txn_start(txn_start), .txn_write(txn_write), .txn_end(txn_end),
		.wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req), .rd_byte(rd_byte), .rd_valid(rd_valid),
		.conv_start(conv_start), .conv_channel(conv_channel), .ref_amp_enable(ref_amp_enable),
		.conv_done(conv_done), .conv_code(conv_code), .conversion_start_pin_n(conversion_start_pin_n),
		.fault_queue_depth(fault_queue_depth), .alarm_active_high(alarm_active_high),
		.alarm_interrupt_mode(alarm_interrupt_mode), .shutdown(shutdown), .filter_bypass(filter_bypass),
		.lower_threshold(lower_threshold), .upper_threshold(upper_threshold)
	);

	tab_conv_model conv_u (
		.clk(clk), .nrst(nrst), .conv_start(conv_start), .delay(dly), .conv_done(conv_done)
	);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic check(string nm, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(int n, logic [7:0] b0, logic [7:0] b1 = 8'h00, logic [7:0] b2 = 8'h00);
		@(posedge clk);
		txn_start <= 1;
		txn_write <= 1;
		@(posedge clk);
		txn_start <= 0;
		for (int i = 0; i < n; i++) begin
			wr_valid <= 1;
			wr_byte <= (i == 0) ? b0 : (i == 1) ? b1 : b2;
			@(posedge clk);
		end
		wr_valid <= 0;
		txn_end <= 1;
		@(posedge clk);
		txn_end <= 0;
	endtask

	task automatic rd(int n, output logic [15:0] v);
		v = 16'h0000;
		@(posedge clk);
		txn_start <= 1;
		txn_write <= 0;
		@(posedge clk);
		txn_start <= 0;
		for (int i = 0; i < n; i++) begin
			rd_req <= 1;
			@(posedge clk);
			rd_req <= 0;
			@(negedge clk);
			check("rd_valid", 1, rd_valid);
			v = {v[7:0], rd_byte};
			@(posedge clk);
		end
		txn_end <= 1;
		@(posedge clk);
		txn_end <= 0;
	endtask

	// Pin is held low until the start shows, then released
	task automatic pulse_pin(logic [2:0] ch);
		int i;
		conversion_start_pin_n <= 0;
		for (i = 0; i < 20 && conv_start !== 1'b1; i++) @(posedge clk);
		check("conv_start", 1, conv_start);
		check("conv_channel", ch, conv_channel);
		conversion_start_pin_n <= 1;
		for (i = 0; i < 80 && ref_amp_enable === 1'b1; i++) @(posedge clk);
		check("amp_off", 0, ref_amp_enable);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_setpoint();
		logic [15:0] v;
		check("reset_depth", 1, fault_queue_depth);
		wr(3, 8'h03, 8'hc9, 8'h80);
		check("upper", 16'h0193, upper_threshold);
		rd(2, v);
		check("upper_read", 16'hc980, v);
		wr(2, 8'h02, 8'h5a);
		check("lower", 16'h00b4, lower_threshold);
		wr(1, 8'h0b);
		check("upper_kept", 16'h0193, upper_threshold);
		rd(2, v);
		check("pointer_low", 16'hc980, v);
	endtask

	task automatic t_config();
		logic [15:0] v;
		logic [2:0]  depth [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
		for (int c = 0; c < 4; c++) begin
			wr(2, 8'h01, {3'h4, c[1:0], 3'h5});
			check("fault_depth", depth[c], fault_queue_depth);
			check("alarm_levels", 16'h0005, {alarm_active_high, alarm_interrupt_mode, shutdown});
			rd(1, v);
			check("primary", {3'h4, c[1:0], 3'h5}, v);
		end
	endtask

	task automatic t_conv();
		logic [15:0] v;
		wr(2, 8'h05, 8'hc0);
		check("filter_bypass", 1, filter_bypass);
		conv_code <= 10'h3ff;
		wr(2, 8'h01, 8'h01);
		pulse_pin(3'h0);
		wr(2, 8'h00, 8'h12);
		rd(2, v);
		check("temperature", 16'hffc0, v);
		conv_code <= 10'h201;
		wr(2, 8'h01, 8'h81);
		pulse_pin(3'h4);
		wr(1, 8'h04);
		rd(2, v);
		check("converter", 16'h8040, v);
		conv_code <= 10'h155;
		wr(2, 8'h01, 8'h41);
		pulse_pin(3'h2);
		wr(1, 8'h04);
		rd(2, v);
		check("converter_ch2", 16'h5540, v);
		wr(1, 8'h05);
		rd(1, v);
		check("secondary", 16'h00c0, v);
	endtask

	// Slow converter answer so the amplifier window is wide
	task automatic t_auto();
		logic [15:0] v;
		int i;
		dly <= 8'h1e;
		conv_code <= 10'h064;
		wr(2, 8'h01, 8'h00);
		wr(2, 8'h05, 8'h00);
		for (i = 0; i < AUTO + 10 && conv_start !== 1'b1; i++) @(posedge clk);
		check("auto_start", 1, conv_start);
		check("auto_period", 1, i >= AUTO - 3);
		repeat (5) @(posedge clk);
		check("amp_on", 1, ref_amp_enable);
		repeat (40) @(posedge clk);
		wr(1, 8'h00);
		rd(2, v);
		check("temperature", 16'h1900, v);
	endtask

	// ----------------------------------------
	// Clock, run and verdict
	// ----------------------------------------
	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		t_setpoint();
		t_config();
		t_conv();
		t_auto();
		print_verdict();
	end

	// Scenarios need about 260 cycles
	initial begin
		repeat (6000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
endmodule
